/* File: tb/rtg_host_model.sv */
// Host model: issues single-byte register writes and reads.
// Assumes strobes are taken on a rising edge and answered at that same edge.
`timescale 1ns/10ps
module rtg_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wr_data,
  output logic            o_via_rap
);
  initial {o_wr_en, o_rd_en, o_addr, o_wr_data, o_via_rap} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic repeater_access_protocol);
    @(posedge i_sys_clk);
    #1;
    {o_wr_en, o_addr, o_wr_data, o_via_rap} = {1'b1, a, d, repeater_access_protocol};
    @(posedge i_sys_clk);
    #1;
    // Released lines toggle so stale data is never mistaken for a request
    {o_wr_en, o_addr, o_wr_data} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    {o_rd_en, o_addr} = {1'b1, a};
    @(posedge i_sys_clk);
    #1;
    {o_rd_en, o_addr} = {1'b0, ~a};
    d = i_rd_valid ? i_rd_data : 8'hxx;
  endtask
endmodule

/* File: tb/rtg_regs_properties.sv */
// Assertions on the tuning register bank, seen from its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module rtg_regs_props #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst_n,
  input wire logic              i_wr_en,
  input wire logic              i_rd_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0]        i_wr_data,
  input wire logic              i_via_rap,
  input wire logic              i_rep0_enabled,
  input wire logic              i_chirp_active,
  input wire logic [7:0]        o_rd_data,
  input wire logic              o_rd_valid,
  input wire logic              o_pin1_out,
  input wire logic              o_pin1_oe,
  input wire logic              o_pin1_irq,
  input wire logic              o_usb_side_emphasis_on,
  input wire logic [1:0]        o_serial_bus_drive_strength,
  input wire logic [3:0]        o_usb_side_detach_threshold,
  input wire logic [2:0]        o_usb_side_quiet_threshold
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence wr_at(a);
    i_wr_en && i_addr == a;
  endsequence
  sequence emph_set;
    wr_at(8'h31) ##0 i_wr_data[3] ##1 (!i_chirp_active && !i_wr_en);
  endsequence
  sequence rx_wr_rd;
    wr_at(8'h39) ##2 (i_rd_en && i_addr == 8'h39 && !i_wr_en);
  endsequence
  rd_answer_a: assert property (i_rd_en |=> o_rd_valid)
    else $error("read strobe got no valid answer");
  unmapped_zero_a: assert property (i_rd_en && i_addr > 8'h50 |=> o_rd_data == 8'h00)
    else $error("unmapped read returned nonzero data");
  chirp_gate_a: assert property (i_chirp_active |=> !o_usb_side_emphasis_on)
    else $error("emphasis active during chirp");
  emph_enable_a: assert property (emph_set |=> o_usb_side_emphasis_on)
    else $error("emphasis not enabled after write");
  rap_guard_a: assert property (wr_at(8'h32) ##0 (i_via_rap && !i_rep0_enabled)
    |=> $stable(o_serial_bus_drive_strength))
    else $error("drive strength changed via guarded write");
  detach_write_a: assert property (wr_at(8'h33) |=>
    o_usb_side_detach_threshold == $past(i_wr_data[7:4])
    && o_usb_side_quiet_threshold == $past(i_wr_data[2:0])) else $error("threshold fields wrong");
  rx_readback_a: assert property (rx_wr_rd |=> o_rd_data == ($past(i_wr_data, 3) & 8'h7f))
    else $error("readback of rx register wrong");
  drive_enable_a: assert property (o_pin1_out |-> o_pin1_oe)
    else $error("pin driven high without enable");
  out_no_irq_a: assert property (o_pin1_oe && $past(o_pin1_oe) |-> !o_pin1_irq)
    else $error("interrupt raised in output mode");
endmodule

bind rtg_regs rtg_regs_props #(.ADDR_W(ADDR_W)) u_props (.*);

/* File: tb/tb_top.sv */
// Self-checking bench for the tuning register bank and pin-1 logic.
// Assumes the host model owns the register port; the pin wire is resolved here.
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] OFS [8] = '{8'h31, 8'h32, 8'h33, 8'h37, 8'h38, 8'h39, 8'h40, 8'h50};
  localparam logic [7:0] RST [8] = '{8'h39, 8'hd2, 8'h74, 8'h40, 8'h0c, 8'h62, 8'h00, 8'h50};
  // Writable bits; reserved and status bits excluded
  localparam logic [7:0] WM [8] = '{8'h7f, 8'hc7, 8'hf7, 8'hf8, 8'h1f, 8'h7f, 8'hef, 8'h7f};
  logic        sys_clk = 1'b0, rst_n = 1'b0, rep0 = 1'b1, otp_valid = 1'b0, chirp = 1'b0;
  logic        ext_lvl = 1'b0, wr_en, rd_en, via_rap, rd_valid, pin_out, pin_oe, pin_irq;
  logic        emph_on;
  logic [7:0]  addr, wr_data, rd_data;
  logic [47:0] otp_data = 48'h0000_0000_0000;
  logic [15:0] ind_src = 16'h0000;
  logic [2:0]  emph_lvl, swing;
  logic        cdp;
  logic [1:0]  u_wid, ds, e_wid, e_rate;
  logic [2:0]  u_boost, u_quiet, e_lvl, e_quiet;
  logic [3:0]  detach, e_boost;
  logic [7:0]  lp1;
  wire         pin_wire = pin_oe ? pin_out : ext_lvl;
  int          errors = 0;
  int          checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  rtg_host_model host (.i_sys_clk(sys_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data), .o_via_rap(via_rap));
  rtg_regs dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wr_data(wr_data), .i_via_rap(via_rap), .i_rep0_enabled(rep0),
    .i_otp_valid(otp_valid), .i_otp_data(otp_data), .i_chirp_active(chirp),
    .i_pin1_level(pin_wire), .i_ind_src(ind_src), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_pin1_out(pin_out), .o_pin1_oe(pin_oe), .o_pin1_irq(pin_irq),
    .o_charge_port_method1_enable(cdp), .o_usb_side_emphasis_width(u_wid),
    .o_usb_side_emphasis_on(emph_on), .o_usb_side_emphasis_level(emph_lvl),
    .o_serial_bus_drive_strength(ds), .o_usb_side_rx_boost(u_boost),
    .o_usb_side_detach_threshold(detach), .o_usb_side_quiet_threshold(u_quiet),
    .o_embedded_side_emphasis_level(e_lvl), .o_embedded_side_emphasis_width(e_wid),
    .o_embedded_side_edge_rate(e_rate), .o_embedded_side_swing(swing),
    .o_embedded_side_quiet_threshold(e_quiet), .o_embedded_side_rx_boost(e_boost),
    .o_port1_lowpower_serial_mode(lp1));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic do_reset(input logic otp);
    rst_n = 1'b0;
    otp_valid = otp;
    wait_cyc(10);
    rst_n = 1'b1;
    wait_cyc(1);
  endtask
  task automatic t_defaults;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      host.rd(OFS[i], d);
      chk(d, RST[i]);
    end
    host.rd(8'h60, d);
    chk(d, 8'h00);
    chk(emph_lvl, 8'h01);
    chk(swing, 8'h04);
    chk(emph_on, 8'h01);
    chk(cdp, 8'h00);
    chk(u_wid, 8'h03);
    chk(ds, 8'h03);
    chk(u_boost, 8'h02);
    chk(detach, 8'h07);
    chk(u_quiet, 8'h04);
    chk(e_lvl, 8'h02);
    chk(e_wid, 8'h00);
    chk(e_rate, 8'h01);
    chk(e_quiet, 8'h06);
    chk(e_boost, 8'h02);
    chk(lp1, 8'h50);
  endtask
  task automatic t_masks;
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 8; i++) begin
        host.wr(OFS[i], k ? 8'h00 : 8'hff, 1'b0);
        host.rd(OFS[i], d);
        chk(d, (RST[i] & ~WM[i]) | (k ? 8'h00 : WM[i]));
      end
    end
  endtask
  task automatic t_guard;
    logic [7:0] d;
    host.wr(8'h32, 8'hc0, 1'b0);
    rep0 = 1'b0;
    host.wr(8'h32, 8'h02, 1'b1);
    host.rd(8'h32, d);
    chk(d, 8'hd2);
    rep0 = 1'b1;
    host.wr(8'h32, 8'h40, 1'b1);
    host.rd(8'h32, d);
    chk(d, 8'h50);
    host.wr(8'h31, 8'h08, 1'b0);
    wait_cyc(3);
    chirp = 1'b1;
    wait_cyc(2);
    chk(emph_on, 8'h00);
    chirp = 1'b0;
    wait_cyc(2);
    chk(emph_on, 8'h01);
  endtask
  task automatic t_pin;
    logic [7:0] d;
    logic [7:0] n;
    host.wr(8'h40, 8'h40, 1'b0);
    ext_lvl = 1'b1;
    wait_cyc(8);
    host.rd(8'h40, d);
    chk(d, 8'h50);
    chk({pin_oe, pin_irq}, 8'h01);
    ext_lvl = 1'b0;
    wait_cyc(8);
    chk(pin_irq, 8'h00);
    host.wr(8'h40, 8'h00, 1'b0);
    ext_lvl = 1'b1;
    n = 8'h00;
    repeat (10) begin
      wait_cyc(1);
      n = n + 8'(pin_irq);
    end
    chk(n, 8'h01);
    for (int c = 0; c < 16; c++) begin
      host.wr(8'h40, 8'ha0 | 8'(c), 1'b0);
      ind_src = 16'h0001 << c;
      wait_cyc(3);
      chk({pin_oe, pin_out}, {1'b1, c != 14});
      ind_src = 16'h0000;
      wait_cyc(3);
      chk({pin_oe, pin_out}, {1'b1, c == 13});
    end
    host.wr(8'h40, 8'h2d, 1'b0);
    wait_cyc(3);
    chk({pin_oe, pin_out}, 8'h00);
    host.wr(8'h40, 8'h2e, 1'b0);
    wait_cyc(3);
    chk({pin_oe, pin_out}, 8'h02);
    ext_lvl = 1'b0;
  endtask
  task automatic t_otp;
    logic [7:0] d;
    otp_data = 48'h1e2d_3c4b_5a69;
    do_reset(1'b1);
    for (int i = 0; i < 8; i++) begin
      host.rd(OFS[i], d);
      chk(d, i < 6 ? (RST[i] & ~WM[i]) | (otp_data[8*i +: 8] & WM[i]) : RST[i]);
    end
    chk(swing, 8'h05);
    chk(e_boost, 8'h0e);
  endtask
  task automatic summarize;
    $display("Checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    t_defaults();
    t_masks();
    t_guard();
    t_pin();
    t_otp();
    summarize();
  end
  initial begin
    #50000;
    errors++;
    summarize();
  end
endmodule

/* File: verilog/rtg_pin1.sv */
// Pin-1 logic: input synchroniser, indicator mux, drive and interrupt.
// Assumes the pin level is asynchronous to the system clock.
`timescale 1ns/10ps
module rtg_pin1 (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  rtg_pin_if.pin           pin_bus,
  input  wire logic        i_pin_level,
  input  wire logic [15:0] i_ind_src,
  output logic             o_pin_out,
  output logic             o_pin_oe,
  output logic             o_irq
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic level_q;
  logic out_q;
  logic oe_q;
  logic irq_q;

  wire settled   = (sync2_q == sync3_q);
  wire level_d   = settled ? sync3_q : level_q;
  wire changed   = settled && (sync3_q != level_q);
  // Codes D and E are static levels, all others pick a status source
  wire ind_val   = (pin_bus.sel == rtg_pkg::SEL_HIGH) ? 1'b1 :
                   (pin_bus.sel == rtg_pkg::SEL_LOW)  ? 1'b0 :
                   i_ind_src[pin_bus.sel];
  // Open drain only pulls low; a high level is left to the pull-up
  wire oe_d      = pin_bus.dir_out && (pin_bus.drive_pp || !ind_val);
  // Held low in input mode so a push-pull setting never shows a level undriven
  wire out_d     = (pin_bus.dir_out && pin_bus.drive_pp) ? ind_val : 1'b0;
  wire irq_d     = pin_bus.dir_out ? 1'b0 :
                   pin_bus.trig_level ? level_d : changed;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      sync1_q <= i_pin_level;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
      irq_q <= irq_d;
    end
  end

  assign pin_bus.sampled_level = level_q;
  assign o_pin_out             = out_q;
  assign o_pin_oe              = oe_q;
  assign o_irq                 = irq_q;

endmodule

/* File: verilog/rtg_pin_if.sv */
// Configuration and status carried between the bank and the pin-1 logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface rtg_pin_if;
  logic       drive_pp;
  logic       trig_level;
  logic       dir_out;
  logic [3:0] sel;
  logic       sampled_level;

  modport regs (output drive_pp, output trig_level, output dir_out, output sel,
                input sampled_level);
  modport pin  (input drive_pp, input trig_level, input dir_out, input sel,
                output sampled_level);
endinterface

/* File: verilog/rtg_pkg.sv */
// Constants for the repeater tuning and pin-1 register bank.
// Assumes byte-wide registers reached through the serial front end.
package rtg_pkg;

  typedef logic [7:0] rtg_byte_t;

  localparam int unsigned NUM_REGS = 8;
  localparam int unsigned NUM_OTP  = 6;

  // Register indices; the OTP-loadable ones come first
  localparam int unsigned IDX_U_PE   = 0;
  localparam int unsigned IDX_U_RX   = 1;
  localparam int unsigned IDX_U_DSQ  = 2;
  localparam int unsigned IDX_E_PE   = 3;
  localparam int unsigned IDX_E_TX   = 4;
  localparam int unsigned IDX_E_RX   = 5;
  localparam int unsigned IDX_PIN1   = 6;
  localparam int unsigned IDX_LP1    = 7;

  localparam rtg_byte_t REG_OFS [NUM_REGS] = '{
    8'h31, 8'h32, 8'h33, 8'h37, 8'h38, 8'h39, 8'h40, 8'h50};
  localparam rtg_byte_t REG_RST [NUM_REGS] = '{
    8'h39, 8'hd2, 8'h74, 8'h40, 8'h0c, 8'h62, 8'h00, 8'h50};
  // Writable bits; the rest hold their reset value
  localparam rtg_byte_t REG_WMASK [NUM_REGS] = '{
    8'h7f, 8'hc7, 8'hf7, 8'hf8, 8'h1f, 8'h7f, 8'hef, 8'h7f};

  // Serial-bus drive strength field in the USB-side rx register
  localparam rtg_byte_t DS_MASK = 8'hc0;

  // Field positions
  localparam int unsigned U_PE_LVL_LSB  = 0;
  localparam int unsigned U_PE_ON_BIT   = 3;
  localparam int unsigned U_PE_WID_LSB  = 4;
  localparam int unsigned CDP1_BIT      = 6;
  localparam int unsigned U_EQ_LSB      = 0;
  localparam int unsigned DS_LSB        = 6;
  localparam int unsigned U_SQ_LSB      = 0;
  localparam int unsigned U_DSC_LSB     = 4;
  localparam int unsigned E_PE_WID_LSB  = 3;
  localparam int unsigned E_PE_LVL_LSB  = 5;
  localparam int unsigned E_AMP_LSB     = 0;
  localparam int unsigned E_SLEW_LSB    = 3;
  localparam int unsigned E_EQ_LSB      = 0;
  localparam int unsigned E_SQ_LSB      = 4;
  localparam int unsigned P1_SEL_LSB    = 0;
  localparam int unsigned P1_LEVEL_BIT  = 4;
  localparam int unsigned P1_DIR_BIT    = 5;
  localparam int unsigned P1_TRIG_BIT   = 6;
  localparam int unsigned P1_PP_BIT     = 7;

  // Indicator select codes with fixed meaning
  localparam logic [3:0] SEL_HIGH = 4'hd;
  localparam logic [3:0] SEL_LOW  = 4'he;

  function automatic rtg_byte_t rtg_merge(input rtg_byte_t old_v,
                                          input rtg_byte_t new_v,
                                          input rtg_byte_t mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

endpackage

/* File: verilog/rtg_regs.sv */
// Byte-wide tuning register bank for port 0 and pin-1 configuration.
// Assumes a serial front end (I2C or repeater access protocol) that
// delivers single-cycle byte read and write strobes on this clock.
`timescale 1ns/10ps
module rtg_regs #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wr_data,
  input  wire logic              i_via_rap,
  input  wire logic              i_rep0_enabled,
  input  wire logic              i_otp_valid,
  input  wire logic [47:0]       i_otp_data,
  input  wire logic              i_chirp_active,
  input  wire logic              i_pin1_level,
  input  wire logic [15:0]       i_ind_src,
  output logic [7:0]             o_rd_data,
  output logic                   o_rd_valid,
  output logic                   o_pin1_out,
  output logic                   o_pin1_oe,
  output logic                   o_pin1_irq,
  output logic                   o_charge_port_method1_enable,
  output logic [1:0]             o_usb_side_emphasis_width,
  output logic                   o_usb_side_emphasis_on,
  output logic [2:0]             o_usb_side_emphasis_level,
  output logic [1:0]             o_serial_bus_drive_strength,
  output logic [2:0]             o_usb_side_rx_boost,
  output logic [3:0]             o_usb_side_detach_threshold,
  output logic [2:0]             o_usb_side_quiet_threshold,
  output logic [2:0]             o_embedded_side_emphasis_level,
  output logic [1:0]             o_embedded_side_emphasis_width,
  output logic [1:0]             o_embedded_side_edge_rate,
  output logic [2:0]             o_embedded_side_swing,
  output logic [2:0]             o_embedded_side_quiet_threshold,
  output logic [3:0]             o_embedded_side_rx_boost,
  output logic [7:0]             o_port1_lowpower_serial_mode
);

  if (ADDR_W < 7) begin : g_chk_addr
    $error("ADDR_W too small for the register map");
  end

  localparam int unsigned NR = rtg_pkg::NUM_REGS;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input rtg_pkg::rtg_byte_t ofs);
    return addr == ADDR_W'(ofs);
  endfunction

  rtg_pkg::rtg_byte_t reg_q [NR];
  rtg_pkg::rtg_byte_t reg_d [NR];
  logic               otp_load_q;
  logic [7:0]         rd_data_q;
  logic               rd_valid_q;
  logic               emph_on_q;
  logic [NR-1:0]      wr_hit;
  logic [NR-1:0]      rd_hit;
  rtg_pkg::rtg_byte_t wmask [NR];
  rtg_pkg::rtg_byte_t rd_val [NR];
  rtg_pkg::rtg_byte_t rd_mux;

  rtg_pin_if pin_bus ();

  // Address decode and effective write masks
  for (genvar g = 0; g < NR; g++) begin : g_dec
    assign wr_hit[g] = i_wr_en && addr_hit(i_addr, rtg_pkg::REG_OFS[g]);
    assign rd_hit[g] = i_rd_en && addr_hit(i_addr, rtg_pkg::REG_OFS[g]);
    if (g == rtg_pkg::IDX_U_RX) begin : g_ds
      // Drive strength is meant for I2C; the protocol path is gated while repeater 0 is disabled
      assign wmask[g] = (i_via_rap && !i_rep0_enabled) ?
                        (rtg_pkg::REG_WMASK[g] & ~rtg_pkg::DS_MASK) :
                        rtg_pkg::REG_WMASK[g];
    end else begin : g_plain
      assign wmask[g] = rtg_pkg::REG_WMASK[g];
    end
    if (g == rtg_pkg::IDX_PIN1) begin : g_lvl
      assign rd_val[g] = rtg_pkg::rtg_byte_t'(
        reg_q[g] | (8'h01 << rtg_pkg::P1_LEVEL_BIT) &
        {8{pin_bus.sampled_level}});
    end else begin : g_rdv
      assign rd_val[g] = reg_q[g];
    end
  end

  // Next-state of every register: reset, factory load for the first six, then writes
  always_comb begin
    for (int i = 0; i < NR; i++) begin
      reg_d[i] = reg_q[i];
      if (otp_load_q && i_otp_valid && i < rtg_pkg::NUM_OTP) begin
        reg_d[i] = rtg_pkg::rtg_merge(rtg_pkg::REG_RST[i],
                                      i_otp_data[i*8 +: 8],
                                      rtg_pkg::REG_WMASK[i]);
      end else if (wr_hit[i]) begin
        reg_d[i] = rtg_pkg::rtg_merge(reg_q[i], i_wr_data, wmask[i]);
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NR; i++) begin
      if (rd_hit[i]) begin
        rd_mux = rd_val[i];
      end
    end
  end

  // Hardware defaults on reset, factory values one cycle after release
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NR; i++) begin
        reg_q[i] <= rtg_pkg::REG_RST[i];
      end
      otp_load_q <= 1'b1;
    end else begin
      for (int i = 0; i < NR; i++) begin
        reg_q[i] <= reg_d[i];
      end
      otp_load_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
      emph_on_q  <= 1'b0;
    end else begin
      rd_data_q  <= rd_mux;
      rd_valid_q <= i_rd_en;
      // Emphasis must never distort chirp, whatever software set
      emph_on_q  <= reg_q[rtg_pkg::IDX_U_PE][rtg_pkg::U_PE_ON_BIT] &&
                    !i_chirp_active;
    end
  end

  // Pin-1 configuration into the pin logic
  assign pin_bus.drive_pp   = reg_q[rtg_pkg::IDX_PIN1][rtg_pkg::P1_PP_BIT];
  assign pin_bus.trig_level = reg_q[rtg_pkg::IDX_PIN1][rtg_pkg::P1_TRIG_BIT];
  assign pin_bus.dir_out    = reg_q[rtg_pkg::IDX_PIN1][rtg_pkg::P1_DIR_BIT];
  assign pin_bus.sel        = reg_q[rtg_pkg::IDX_PIN1][rtg_pkg::P1_SEL_LSB +: 4];

  rtg_pin1 u_pin1 (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .pin_bus     (pin_bus.pin),
    .i_pin_level (i_pin1_level),
    .i_ind_src   (i_ind_src),
    .o_pin_out   (o_pin1_out),
    .o_pin_oe    (o_pin1_oe),
    .o_irq       (o_pin1_irq)
  );

  assign o_rd_data  = rd_data_q;
  assign o_rd_valid = rd_valid_q;

  // Tuning fields to the analog blocks
  assign o_charge_port_method1_enable =
    reg_q[rtg_pkg::IDX_U_PE][rtg_pkg::CDP1_BIT];
  assign o_usb_side_emphasis_width =
    reg_q[rtg_pkg::IDX_U_PE][rtg_pkg::U_PE_WID_LSB +: 2];
  assign o_usb_side_emphasis_on = emph_on_q;
  assign o_usb_side_emphasis_level =
    reg_q[rtg_pkg::IDX_U_PE][rtg_pkg::U_PE_LVL_LSB +: 3];
  assign o_serial_bus_drive_strength =
    reg_q[rtg_pkg::IDX_U_RX][rtg_pkg::DS_LSB +: 2];
  assign o_usb_side_rx_boost =
    reg_q[rtg_pkg::IDX_U_RX][rtg_pkg::U_EQ_LSB +: 3];
  assign o_usb_side_detach_threshold =
    reg_q[rtg_pkg::IDX_U_DSQ][rtg_pkg::U_DSC_LSB +: 4];
  assign o_usb_side_quiet_threshold =
    reg_q[rtg_pkg::IDX_U_DSQ][rtg_pkg::U_SQ_LSB +: 3];
  assign o_embedded_side_emphasis_level =
    reg_q[rtg_pkg::IDX_E_PE][rtg_pkg::E_PE_LVL_LSB +: 3];
  assign o_embedded_side_emphasis_width =
    reg_q[rtg_pkg::IDX_E_PE][rtg_pkg::E_PE_WID_LSB +: 2];
  assign o_embedded_side_edge_rate =
    reg_q[rtg_pkg::IDX_E_TX][rtg_pkg::E_SLEW_LSB +: 2];
  assign o_embedded_side_swing =
    reg_q[rtg_pkg::IDX_E_TX][rtg_pkg::E_AMP_LSB +: 3];
  assign o_embedded_side_quiet_threshold =
    reg_q[rtg_pkg::IDX_E_RX][rtg_pkg::E_SQ_LSB +: 3];
  assign o_embedded_side_rx_boost =
    reg_q[rtg_pkg::IDX_E_RX][rtg_pkg::E_EQ_LSB +: 4];
  assign o_port1_lowpower_serial_mode = reg_q[rtg_pkg::IDX_LP1];

endmodule
